// ===== verilog/dsfr_pkg.sv
// package: status bit layout, register map and timing constants for the status reporter
package dsfr_pkg;
  // apb register byte offsets
  localparam logic [7:0] DSFR_OFF_STATUS = 8'h00;
  localparam logic [7:0] DSFR_OFF_REQ = 8'h04;
  localparam logic [7:0] DSFR_OFF_DRIVE = 8'h08;
  localparam logic [7:0] DSFR_OFF_SELECT = 8'h0C;
  localparam logic [7:0] DSFR_OFF_FREQ = 8'h10;
  localparam logic [7:0] DSFR_OFF_TOL = 8'h14;
  localparam logic [7:0] DSFR_OFF_MONSEL = 8'h18;
  localparam logic [7:0] DSFR_OFF_MONREPLY = 8'h1C;
  localparam logic [7:0] DSFR_OFF_INSTR = 8'h20;
  localparam logic [7:0] DSFR_OFF_SETFREQ = 8'h24;
  localparam logic [7:0] DSFR_OFF_OUTFREQ = 8'h28;
  // status word bit positions
  localparam int DSFR_BIT_FWD = 0;
  localparam int DSFR_BIT_REV = 1;
  localparam int DSFR_BIT_SEL0 = 2;
  localparam int DSFR_BIT_MON = 12;
  localparam int DSFR_BIT_VFREQ = 13;
  localparam int DSFR_BIT_NVFREQ = 14;
  localparam int DSFR_BIT_INSTR = 15;
  localparam int DSFR_BIT_ERR = 26;
  localparam int DSFR_BIT_READY = 27;
  // request word bit positions
  localparam int DSFR_REQ_MON = 0;
  localparam int DSFR_REQ_VFREQ = 1;
  localparam int DSFR_REQ_NVFREQ = 2;
  localparam int DSFR_REQ_INSTR = 3;
  localparam int DSFR_REQ_ERRRST = 4;
  // internal status source codes for the six selectable bits
  localparam logic [2:0] DSFR_SRC_RUN = 3'h0;
  localparam logic [2:0] DSFR_SRC_SPEED = 3'h1;
  localparam logic [2:0] DSFR_SRC_STALL = 3'h2;
  localparam logic [2:0] DSFR_SRC_DIP = 3'h3;
  localparam logic [2:0] DSFR_SRC_FDET = 3'h4;
  localparam logic [2:0] DSFR_SRC_ALARM = 3'h5;
  // default mapping: slot i driven by source i
  localparam logic [17:0] DSFR_SELECT_RST = 18'h2C688;
  localparam logic [15:0] DSFR_TOL_RST = 16'h0064;
  // setup time after reset before ready
  localparam int DSFR_SETUP_NS = 1000;
  localparam int DSFR_CLK_NS = 10;
  localparam int DSFR_SETUP_CYC = (DSFR_SETUP_NS + DSFR_CLK_NS - 1) / DSFR_CLK_NS;
  // cycles for a frequency store or an instruction to finish
  localparam int DSFR_STORE_CYC = 4;
  localparam int DSFR_EXEC_CYC = 8;

  typedef enum logic [2:0] {
    DSFR_ST_SETUP = 3'b001,
    DSFR_ST_READY = 3'b010,
    DSFR_ST_FAULT = 3'b100
  } dsfr_state_t;

  typedef struct packed {
    logic motorFwd;
    logic motorRev;
    logic outputRunning;
    logic stall_prevention_signal;
    logic power_dip_signal;
    logic protectiveTrip;
  } dsfr_drive_t;

  typedef struct packed {
    dsfr_state_t state;
    logic [7:0] setupCnt;
    logic [31:0] status;
    logic [5:0] req;
    logic [15:0] driveRaw;
    logic [17:0] select;
    logic [15:0] cmdFreq;
    logic [15:0] tol;
    logic [15:0] monSel;
    logic [15:0] monitor_reply_register;
    logic [15:0] instruction_word_register;
    logic [15:0] setFreq;
    logic [3:0] vCnt;
    logic [3:0] nvCnt;
    logic [3:0] iCnt;
    logic [31:0] prdata;
  } dsfr_regs_t;
endpackage : dsfr_pkg

// ===== verilog/dsfr_reporter.sv
// drive status flag reporter: cyclic status word behind an apb slave
//
// Operation
// - forward flag high only while motor turns forward
// - reverse flag high only while motor turns in reverse
// - output-active flag follows the running drive output
// - at-speed flag when output frequency within tolerance of command
// - stall-prevention flag follows stall prevention activity
// - power-dip flag on momentary supply loss or undervoltage
// - frequency-detect flag when output reaches commanded frequency
// - alarm flag when a protective trip stops the output
// - select register remaps sources of the six selectable bits
// - monitoring flag after reply loaded, drops with the request
// - volatile frequency done after store, clears with request
// - nonvolatile frequency done after write, clears with request
// - instruction done when processing finishes after execute request
// - error flag set whenever a protective function trips
// - ready flag only after initial setup following reset
// - ready flag drops on a protective trip
// - error reset during fault restarts device; ignored otherwise
// - reply register refreshed while monitor request stays high
`timescale 1ns/1ps
module dsfr_reporter (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dsfr_pkg::dsfr_drive_t drive,
  input wire logic [15:0] outFreq,
  output logic [31:0] statusWord
);
  dsfr_pkg::dsfr_regs_t r, n;
  logic [5:0] src;
  logic [5:0] sel6;
  logic atSpeed;
  logic freqHit;
  logic fault;
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic errRstReq;
  logic [31:0] rdVal;

  function automatic logic [15:0] absDiff(input logic [15:0] a, input logic [15:0] b);
    absDiff = (a > b) ? a - b : b - a;
  endfunction : absDiff

  // --------------------------------------------------------------
  // internal status sources
  // --------------------------------------------------------------
  always_comb begin
    // fault is the drive trip input ORed with bit 5 of what software pokes into the raw mirror
    fault = drive.protectiveTrip | r.driveRaw[5];
    atSpeed = drive.outputRunning && absDiff(outFreq, r.cmdFreq) <= r.tol;
    freqHit = drive.outputRunning && outFreq >= r.cmdFreq;
    src = '0;
    src[dsfr_pkg::DSFR_SRC_RUN] = drive.outputRunning;
    src[dsfr_pkg::DSFR_SRC_SPEED] = atSpeed;
    src[dsfr_pkg::DSFR_SRC_STALL] = drive.stall_prevention_signal;
    src[dsfr_pkg::DSFR_SRC_DIP] = drive.power_dip_signal;
    src[dsfr_pkg::DSFR_SRC_FDET] = freqHit;
    src[dsfr_pkg::DSFR_SRC_ALARM] = fault;
    // codes above five select nothing and read low
    for (int i = 0; i < 6; i++) begin
      sel6[i] = (r.select[3*i +: 3] < 3'h6) ? src[r.select[3*i +: 3]] : 1'b0;
    end
  end

  // --------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------
  always_comb begin
    wrEn = psel && penable && pwrite;
    rdEn = psel && !penable && !pwrite;
    mapped = 1'b1;
    rdVal = '0;
    unique case (paddr)
      dsfr_pkg::DSFR_OFF_STATUS: rdVal = r.status;
      dsfr_pkg::DSFR_OFF_REQ: rdVal = {26'h0, r.req};
      dsfr_pkg::DSFR_OFF_DRIVE: rdVal = {16'h0, r.driveRaw};
      dsfr_pkg::DSFR_OFF_SELECT: rdVal = {14'h0, r.select};
      dsfr_pkg::DSFR_OFF_FREQ: rdVal = {16'h0, r.cmdFreq};
      dsfr_pkg::DSFR_OFF_TOL: rdVal = {16'h0, r.tol};
      dsfr_pkg::DSFR_OFF_MONSEL: rdVal = {16'h0, r.monSel};
      dsfr_pkg::DSFR_OFF_MONREPLY: rdVal = {16'h0, r.monitor_reply_register};
      dsfr_pkg::DSFR_OFF_INSTR: rdVal = {16'h0, r.instruction_word_register};
      dsfr_pkg::DSFR_OFF_SETFREQ: rdVal = {16'h0, r.setFreq};
      dsfr_pkg::DSFR_OFF_OUTFREQ: rdVal = {16'h0, outFreq};
      default: mapped = 1'b0;
    endcase
    pready = 1'b1;
    pslverr = psel && penable && !mapped;
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    n = r;
    errRstReq = r.req[dsfr_pkg::DSFR_REQ_ERRRST];
    if (rdEn) begin
      n.prdata = rdVal;
    end
    if (wrEn && mapped) begin
      unique case (paddr)
        dsfr_pkg::DSFR_OFF_REQ: n.req = pwdata[5:0];
        dsfr_pkg::DSFR_OFF_DRIVE: n.driveRaw = pwdata[15:0];
        dsfr_pkg::DSFR_OFF_SELECT: n.select = pwdata[17:0];
        dsfr_pkg::DSFR_OFF_FREQ: n.cmdFreq = pwdata[15:0];
        dsfr_pkg::DSFR_OFF_TOL: n.tol = pwdata[15:0];
        dsfr_pkg::DSFR_OFF_MONSEL: n.monSel = pwdata[15:0];
        dsfr_pkg::DSFR_OFF_INSTR: n.instruction_word_register = pwdata[15:0];
        default: ;
      endcase
    end
    // monitor: reply tracks the chosen value every cycle while requested
    if (r.req[dsfr_pkg::DSFR_REQ_MON]) begin
      n.monitor_reply_register = (r.monSel == 16'h0000) ? outFreq : r.cmdFreq;
    end
    // completion counters run only while their request is held
    n.vCnt = r.req[dsfr_pkg::DSFR_REQ_VFREQ] ? ((r.vCnt == 4'hF) ? r.vCnt : r.vCnt + 4'h1) : 4'h0;
    n.nvCnt = r.req[dsfr_pkg::DSFR_REQ_NVFREQ] ?
              ((r.nvCnt == 4'hF) ? r.nvCnt : r.nvCnt + 4'h1) : 4'h0;
    n.iCnt = r.req[dsfr_pkg::DSFR_REQ_INSTR] ? ((r.iCnt == 4'hF) ? r.iCnt : r.iCnt + 4'h1) : 4'h0;
    if (r.vCnt == 4'(dsfr_pkg::DSFR_STORE_CYC) || r.nvCnt == 4'(dsfr_pkg::DSFR_STORE_CYC)) begin
      n.setFreq = r.cmdFreq;
    end
    unique case (r.state)
      dsfr_pkg::DSFR_ST_SETUP: begin
        n.setupCnt = r.setupCnt + 8'h01;
        // a trip during setup still has to show as an error at once
        if (fault) begin
          n.state = dsfr_pkg::DSFR_ST_FAULT;
        end else if (r.setupCnt == 8'(dsfr_pkg::DSFR_SETUP_CYC - 1)) begin
          n.state = dsfr_pkg::DSFR_ST_READY;
        end
      end
      dsfr_pkg::DSFR_ST_READY: begin
        if (fault) begin
          n.state = dsfr_pkg::DSFR_ST_FAULT;
        end
      end
      dsfr_pkg::DSFR_ST_FAULT: begin
        // reset request only counts in the fault state, whether or not the trip is still present
        if (errRstReq) begin
          n.state = dsfr_pkg::DSFR_ST_SETUP;
          n.setupCnt = 8'h00;
          n.req = '0;
          n.driveRaw = '0;
        end
      end
      default: n.state = dsfr_pkg::DSFR_ST_SETUP;
    endcase
    // ----- status word -----
    n.status = '0;
    n.status[dsfr_pkg::DSFR_BIT_FWD] = drive.motorFwd && !drive.motorRev;
    n.status[dsfr_pkg::DSFR_BIT_REV] = drive.motorRev && !drive.motorFwd;
    n.status[dsfr_pkg::DSFR_BIT_SEL0 +: 6] = sel6;
    n.status[dsfr_pkg::DSFR_BIT_MON] = r.req[dsfr_pkg::DSFR_REQ_MON] &&
                                       (r.status[dsfr_pkg::DSFR_BIT_MON] ||
                                        r.monitor_reply_register == n.monitor_reply_register);
    n.status[dsfr_pkg::DSFR_BIT_VFREQ] = r.req[dsfr_pkg::DSFR_REQ_VFREQ] &&
                                         r.vCnt >= 4'(dsfr_pkg::DSFR_STORE_CYC);
    n.status[dsfr_pkg::DSFR_BIT_NVFREQ] = r.req[dsfr_pkg::DSFR_REQ_NVFREQ] &&
                                          r.nvCnt >= 4'(dsfr_pkg::DSFR_STORE_CYC);
    n.status[dsfr_pkg::DSFR_BIT_INSTR] = r.req[dsfr_pkg::DSFR_REQ_INSTR] &&
                                         r.iCnt >= 4'(dsfr_pkg::DSFR_EXEC_CYC);
    n.status[dsfr_pkg::DSFR_BIT_ERR] = (n.state == dsfr_pkg::DSFR_ST_FAULT);
    n.status[dsfr_pkg::DSFR_BIT_READY] = (n.state == dsfr_pkg::DSFR_ST_READY);
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r <= '{state: dsfr_pkg::DSFR_ST_SETUP, select: dsfr_pkg::DSFR_SELECT_RST,
             tol: dsfr_pkg::DSFR_TOL_RST, default: '0};
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign statusWord = r.status;
endmodule : dsfr_reporter

// ===== sim/dsfr_reporter_sva.sv
// checker: port properties of the status reporter
`timescale 1ns/1ps
module dsfr_reporter_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dsfr_pkg::dsfr_drive_t drive,
  input wire logic [15:0] outFreq,
  input wire logic [31:0] statusWord
);
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [7:0] lowCnt_r;
  logic reqWr;
  assign reqWr = psel && penable && pwrite && paddr == dsfr_pkg::DSFR_OFF_REQ;
  // cycles spent not ready, saturating
  always_ff @(posedge sys_clk) begin
    if (reset || statusWord[27]) lowCnt_r <= 8'h00;
    else if (lowCnt_r != 8'hFF) lowCnt_r <= lowCnt_r + 8'h01;
  end
  a_fwd_flag: assert property (statusWord[27] && $past(statusWord[27]) |->
    statusWord[0] == ($past(drive.motorFwd) && !$past(drive.motorRev))) else $error("fwd");
  a_rev_flag: assert property (statusWord[27] && $past(statusWord[27]) |->
    statusWord[1] == ($past(drive.motorRev) && !$past(drive.motorFwd))) else $error("rev");
  a_reserved_zero: assert property ((statusWord & 32'hF3FF0F00) == 32'h0)
    else $error("reserved bit set");
  a_trip_error: assert property (drive.protectiveTrip |=> statusWord[26])
    else $error("no error on trip");
  a_err_unready: assert property (statusWord[26] |-> !statusWord[27])
    else $error("ready during fault");
  a_ready_setup: assert property ($rose(statusWord[27]) |-> lowCnt_r >= 8'h5A)
    else $error("ready too early");
  a_mon_drop: assert property (reqWr && !pwdata[0] |-> ##[1:3] !statusWord[12])
    else $error("monitor flag stuck");
  a_vfreq_drop: assert property (reqWr && !pwdata[1] |-> ##[1:3] !statusWord[13])
    else $error("volatile done stuck");
  a_instr_drop: assert property (reqWr && !pwdata[3] |-> ##[1:3] !statusWord[15])
    else $error("instr done stuck");
  a_bus_slverr: assert property (psel && penable && paddr > 8'h28 |-> pslverr && pready)
    else $error("unmapped not refused");
  c_ready: cover property ($rose(statusWord[27]));
  c_fault: cover property ($rose(statusWord[26]));
  c_instr: cover property ($rose(statusWord[15]));
endmodule : dsfr_reporter_sva
bind dsfr_reporter dsfr_reporter_sva i_sva (.sys_clk, .reset, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .drive, .outFreq, .statusWord);

// ===== sim/dsfr_master_model.sv
// master model: apb requester standing in for the fieldbus master
`timescale 1ns/1ps
module dsfr_master_model (
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] statusWord
);
  logic lastErr;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge sys_clk);
      n++;
    end
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale data must not look valid once released
    pwdata <= ~d;
    @(posedge sys_clk);
  endtask : xfer
  task automatic wait_ready(output logic ok);
    int n;
    n = 0;
    while (statusWord[27] !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    ok = statusWord[27];
  endtask : wait_ready
endmodule : dsfr_master_model

// ===== sim/dsfr_reporter_tb_top.sv
// testbench: scenarios for the drive status flag reporter
`timescale 1ns/1ps
module dsfr_reporter_tb_top;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, ok;
  logic [7:0] paddr;
  logic [15:0] outFreq;
  logic [31:0] pwdata, prdata, statusWord, rd;
  dsfr_pkg::dsfr_drive_t drive;
  int fail_count, comparisons;
  dsfr_reporter i_dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .drive, .outFreq, .statusWord);
  dsfr_master_model i_master (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .statusWord);
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_master.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    i_master.xfer(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask : rdchk
  task automatic run(input dsfr_pkg::dsfr_drive_t d, input logic [15:0] f);
    drive <= d;
    outFreq <= f;
    repeat (3) @(posedge sys_clk);
  endtask : run
  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    while (statusWord[b] !== v && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(statusWord[b]), 32'(v));
  endtask : wait_bit
  task automatic t_reset;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (80) @(posedge sys_clk);
    chk(statusWord, 32'h0);
    i_master.wait_ready(ok);
    chk(32'(ok), 32'h1);
  endtask : t_reset
  task automatic t_bus;
    rdchk(8'h40, 32'h0);
    chk(32'(i_master.lastErr), 32'h1);
    rdchk(dsfr_pkg::DSFR_OFF_TOL, 32'h64);
    wr(dsfr_pkg::DSFR_OFF_STATUS, 32'hFFFFFFFF);
    chk(statusWord & 32'hF3FF0F00, 32'h0);
  endtask : t_bus
  task automatic t_flags;
    wr(dsfr_pkg::DSFR_OFF_FREQ, 32'h100);
    run(6'h28, 16'h0164);
    chk(statusWord & 32'hFF, 32'h4D);
    run(6'h18, 16'h0165);
    chk(statusWord & 32'hFF, 32'h46);
    run(6'h3E, 16'h00FF);
    chk(statusWord & 32'hFF, 32'h3C);
    run(6'h00, 16'h0100);
    chk(statusWord & 32'hFF, 32'h00);
  endtask : t_flags
  task automatic t_remap;
    rdchk(dsfr_pkg::DSFR_OFF_SELECT, 32'h2C688);
    wr(dsfr_pkg::DSFR_OFF_SELECT, 32'h3A);
    run(6'h2C, 16'h0);
    chk(statusWord & 32'hFF, 32'hF5);
    wr(dsfr_pkg::DSFR_OFF_SELECT, 32'h2C688);
    run(6'h00, 16'h0);
  endtask : t_remap
  task automatic t_hand;
    wr(dsfr_pkg::DSFR_OFF_MONSEL, 32'h0);
    outFreq <= 16'h0123;
    wr(dsfr_pkg::DSFR_OFF_REQ, 32'h1);
    wait_bit(12, 1'b1);
    rdchk(dsfr_pkg::DSFR_OFF_MONREPLY, 32'h0123);
    outFreq <= 16'h0456;
    repeat (4) @(posedge sys_clk);
    rdchk(dsfr_pkg::DSFR_OFF_MONREPLY, 32'h0456);
    wr(dsfr_pkg::DSFR_OFF_REQ, 32'h0);
    wait_bit(12, 1'b0);
    for (int i = 1; i < 4; i++) begin
      wr(dsfr_pkg::DSFR_OFF_REQ, 32'(1 << i));
      chk(32'(statusWord[12 + i]), 32'h0);
      wait_bit(12 + i, 1'b1);
      wr(dsfr_pkg::DSFR_OFF_REQ, 32'h0);
      wait_bit(12 + i, 1'b0);
    end
    rdchk(dsfr_pkg::DSFR_OFF_SETFREQ, 32'h0100);
  endtask : t_hand
  task automatic t_fault;
    wr(dsfr_pkg::DSFR_OFF_REQ, 32'h10);
    run(6'h00, 16'h0);
    chk(statusWord & 32'h0C000000, 32'h08000000);
    wr(dsfr_pkg::DSFR_OFF_REQ, 32'h0);
    run(6'h01, 16'h0);
    chk(statusWord & 32'h0C000080, 32'h04000080);
    run(6'h00, 16'h0);
    wr(dsfr_pkg::DSFR_OFF_REQ, 32'h10);
    run(6'h00, 16'h0);
    chk(statusWord & 32'h0C000000, 32'h0);
    i_master.wait_ready(ok);
    chk(32'(ok), 32'h1);
  endtask : t_fault
  task automatic finish_test;
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    drive = '0;
    outFreq = 16'h0;
    fail_count = 0;
    comparisons = 0;
    t_reset();
    t_bus();
    t_flags();
    t_remap();
    t_hand();
    t_fault();
    finish_test();
  end
  // whole run needs about 320 cycles
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule : dsfr_reporter_tb_top
